// >>> hw/sbr_pkg.sv
// sbr_pkg: register map, field positions, reset values for the serial
// bit-rate and status-flag block.
// assumes a 32-bit AHB-Lite slave; one aligned word per register.
package sbr_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_RATE = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_DATA = 8'h10;
    // control one fields
    localparam int C1_RXIE = 7;
    localparam int C1_ENA = 6;
    localparam int C1_TXIE = 5;
    localparam int C1_MASTER_SELECT = 4;
    localparam int C1_SELECT_OUTPUT_ENABLE = 1;
    // control two fields
    localparam int C2_FAULT_FUNCTION_ENABLE = 4;
    // rate register fields, rate and control two write masks
    localparam int BR_PRE_LSB = 4;
    localparam int BR_RATE_LSB = 0;
    localparam logic [7:0] BR_MASK = 8'h77;
    localparam logic [7:0] C2_MASK = 8'h1b;
    // status fields
    localparam int ST_RXF = 7;
    localparam int ST_TXE = 5;
    localparam int ST_MODE_FAULT_FLAG = 4;
    // reset values
    localparam logic [7:0] CTRL1_RST = 8'h04;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] RATE_RST = 8'h00;
    // bits per byte on the link
    localparam int BYTE_BITS = 8;
    // ahb transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : sbr_pkg

// >>> hw/sbr_tick_if.sv
// sbr_tick_if: bit-rate tick between the divider and the core.
// assumes one clock domain.
`timescale 1ns/1ps
interface sbr_tick_if;
    logic [2:0] prescaleSel;
    logic [2:0] rateSel;
    logic run;
    logic halfTick;
    modport gen (input prescaleSel, input rateSel, input run,
        output halfTick);
    modport core (output prescaleSel, output rateSel, output run,
        input halfTick);
endinterface : sbr_tick_if

// >>> hw/sbr_rate_gen.sv
// sbr_rate_gen: prescaler and power-of-two divider giving half-bit ticks.
// assumes selects are stable while run is high or change harmlessly.
`timescale 1ns/1ps
module sbr_rate_gen (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // tick link
    sbr_tick_if.gen tk
);
    logic [2:0] preCnt_reg;
    logic [7:0] divCnt_reg;
    logic preTick;
    logic [7:0] halfLimit;

    // prescale factor is field plus one
    assign preTick = (preCnt_reg == tk.prescaleSel);
    // half of 2^(rate+1) is 2^rate prescaled ticks per half bit
    assign halfLimit = 8'((9'h001 << tk.rateSel) - 9'h001);

    // prescaler counter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            preCnt_reg <= 3'h0;
        end else if (!tk.run || preTick) begin
            preCnt_reg <= 3'h0;
        end else begin
            preCnt_reg <= preCnt_reg + 3'h1;
        end
    end

    // divider counter and half-bit tick
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            divCnt_reg <= 8'h00;
            tk.halfTick <= 1'b0;
        end else if (!tk.run) begin
            divCnt_reg <= 8'h00;
            tk.halfTick <= 1'b0;
        end else if (preTick) begin
            tk.halfTick <= (divCnt_reg == halfLimit);
            divCnt_reg <= (divCnt_reg == halfLimit) ? 8'h00
                : divCnt_reg + 8'h01;
        end else begin
            tk.halfTick <= 1'b0;
        end
    end
endmodule : sbr_rate_gen

// >>> hw/sbr_spi_core.sv
// sbr_spi_core: serial bit-rate generator and status-flag logic with a
// small master shifter, reached over AHB-Lite.
// assumes one slave on the bus, word accesses, single clock mclk.
// How it works
// - rate register accessible at any time
// - prescale factor is field plus one
// - divider is two to power rate-plus-one
// - unused status bits zero, writes ignored
// - transfer completion sets receive full
// - receive full clears: status read, data read
// - transmit empty high when buffer has room
// - transmit empty clears: status read, data write
// - data write without armed status read discarded
// - transmit interrupt from flag and enable
// - idle shifter loads byte within two cycles
// - queued byte loads when shift finishes
// - nothing queued: flag stays, nothing loads
// - master with select low sets mode fault
// - fault only when master, enable, no output
// - fault clears: status read, control one write
// - receive/fault interrupt from flags and enable
// - disable aborts, clears receive, sets empty
// - master data write starts a transfer
// - overrun drops new byte silently
`timescale 1ns/1ps
module sbr_spi_core (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial link
    input wire logic selectInN,
    input wire logic dataIn,
    output logic dataOut,
    output logic serialClock,
    // interrupt requests
    output logic txIrq,
    output logic rxFaultIrq
);
    sbr_tick_if tk ();
    logic [7:0] ctrl1_reg, ctrl2_reg, rate_reg;
    logic rxFull_reg, txEmpty_reg, modeFault_reg;
    logic rxArm_reg, txArm_reg, faultArm_reg;
    logic [7:0] txBuf_reg, rxBuf_reg, shift_reg;
    logic txPending_reg, busy_reg;
    logic [3:0] edgeCnt_reg;
    logic wrPend_reg, rdPend_reg;
    logic [7:0] addr_reg;
    logic addrPhase, doWrite, doRead, enabled, master, faultMode;
    logic wrData, wrCtrl1, rdStat, rdData, shiftDone, loadShift;
    logic [7:0] statusVal;
    typedef enum {SBR_IDLE, SBR_SHIFT} sbr_state_t;
    sbr_state_t state_reg;

    sbr_rate_gen rateGen (
        .mclk(mclk),
        .rst(rst),
        .tk(tk)
    );

    assign tk.prescaleSel = rate_reg[sbr_pkg::BR_PRE_LSB +: 3];
    assign tk.rateSel = rate_reg[sbr_pkg::BR_RATE_LSB +: 3];
    assign tk.run = busy_reg;

    // bus decode: address phase captured, writes and data reads act in data phase, status read in address phase
    assign addrPhase = hsel && hready && (htrans == sbr_pkg::HTRANS_NONSEQ);
    assign doWrite = wrPend_reg;
    assign doRead = rdPend_reg;
    assign wrData = doWrite && addr_reg == sbr_pkg::OFF_DATA;
    assign wrCtrl1 = doWrite && addr_reg == sbr_pkg::OFF_CTRL1;
    assign rdStat = addrPhase && !hwrite && haddr == sbr_pkg::OFF_STAT;
    assign rdData = doRead && addr_reg == sbr_pkg::OFF_DATA;
    assign enabled = ctrl1_reg[sbr_pkg::C1_ENA];
    assign master = ctrl1_reg[sbr_pkg::C1_MASTER_SELECT];
    assign faultMode = master && ctrl2_reg[sbr_pkg::C2_FAULT_FUNCTION_ENABLE]
        && !ctrl1_reg[sbr_pkg::C1_SELECT_OUTPUT_ENABLE];
    assign statusVal = {rxFull_reg, 1'b0, txEmpty_reg, modeFault_reg,
        4'h0};
    assign shiftDone = busy_reg && tk.halfTick
        && edgeCnt_reg == 4'(2 * sbr_pkg::BYTE_BITS - 1);
    assign loadShift = enabled && master && txPending_reg
        && (!busy_reg || shiftDone);

    // capture address phase
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wrPend_reg <= addrPhase && hwrite;
            rdPend_reg <= addrPhase && !hwrite;
            if (addrPhase) begin
                addr_reg <= haddr;
            end
        end
    end

    // read data and zero-wait response
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (addrPhase && !hwrite) begin
            unique case (haddr)
                sbr_pkg::OFF_CTRL1: hrdata <= {24'h0, ctrl1_reg};
                sbr_pkg::OFF_CTRL2: hrdata <= {24'h0, ctrl2_reg};
                sbr_pkg::OFF_RATE: hrdata <= {24'h0, rate_reg};
                sbr_pkg::OFF_STAT: hrdata <= {24'h0, statusVal};
                sbr_pkg::OFF_DATA: hrdata <= {24'h0, rxBuf_reg};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // control and rate registers, writable any time
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl1_reg <= sbr_pkg::CTRL1_RST;
            ctrl2_reg <= sbr_pkg::CTRL2_RST;
            rate_reg <= sbr_pkg::RATE_RST;
        end else if (doWrite) begin
            if (addr_reg == sbr_pkg::OFF_CTRL1) begin
                ctrl1_reg <= hwdata[7:0];
            end
            if (addr_reg == sbr_pkg::OFF_CTRL2) begin
                ctrl2_reg <= hwdata[7:0] & sbr_pkg::C2_MASK;
            end
            if (addr_reg == sbr_pkg::OFF_RATE) begin
                rate_reg <= hwdata[7:0] & sbr_pkg::BR_MASK;
            end
        end
    end

    // arm bits: status read that saw each flag set
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxArm_reg <= 1'b0;
            txArm_reg <= 1'b0;
            faultArm_reg <= 1'b0;
        end else begin
            if (rdStat) begin
                rxArm_reg <= rxFull_reg;
                txArm_reg <= txEmpty_reg;
                faultArm_reg <= modeFault_reg;
            end else begin
                if (rdData) rxArm_reg <= 1'b0;
                if (wrData) txArm_reg <= 1'b0;
                if (wrCtrl1) faultArm_reg <= 1'b0;
            end
        end
    end

    // transmit buffer and empty flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            txBuf_reg <= 8'h00;
            txPending_reg <= 1'b0;
            txEmpty_reg <= 1'b1;
        end else if (!enabled) begin
            txPending_reg <= 1'b0;
            txEmpty_reg <= 1'b1;
        end else if (wrData && txArm_reg && txEmpty_reg) begin
            txBuf_reg <= hwdata[7:0];
            txPending_reg <= 1'b1;
            txEmpty_reg <= 1'b0;
        end else if (loadShift) begin
            txPending_reg <= 1'b0;
            txEmpty_reg <= 1'b1;
        end
        // other data writes fall through unused
    end

    // shifter state machine
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= SBR_IDLE;
            busy_reg <= 1'b0;
            edgeCnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            serialClock <= 1'b0;
            dataOut <= 1'b0;
        end else if (!enabled) begin
            state_reg <= SBR_IDLE;
            busy_reg <= 1'b0;
            serialClock <= 1'b0;
        end else begin
            unique case (state_reg)
                SBR_IDLE: begin
                    if (loadShift) begin
                        state_reg <= SBR_SHIFT;
                        busy_reg <= 1'b1;
                        edgeCnt_reg <= 4'h0;
                        shift_reg <= txBuf_reg;
                        dataOut <= txBuf_reg[7];
                    end
                end
                SBR_SHIFT: begin
                    if (tk.halfTick) begin
                        serialClock <= !serialClock;
                        edgeCnt_reg <= edgeCnt_reg + 4'h1;
                        if (!edgeCnt_reg[0]) begin
                            shift_reg <= {shift_reg[6:0], dataIn};
                        end else begin
                            dataOut <= shift_reg[7];
                        end
                    end
                    if (shiftDone) begin
                        if (loadShift) begin
                            shift_reg <= txBuf_reg;
                            dataOut <= txBuf_reg[7];
                            edgeCnt_reg <= 4'h0;
                        end else begin
                            state_reg <= SBR_IDLE;
                            busy_reg <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // receive buffer and full flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxBuf_reg <= 8'h00;
            rxFull_reg <= 1'b0;
        end else if (!enabled) begin
            rxFull_reg <= 1'b0;
        end else if (shiftDone) begin
            rxFull_reg <= 1'b1;
            if (!rxFull_reg) begin
                rxBuf_reg <= shift_reg;
            end
        end else if (rdData && rxArm_reg) begin
            rxFull_reg <= 1'b0;
        end
    end

    // mode fault flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            modeFault_reg <= 1'b0;
        end else if (faultMode && !selectInN) begin
            modeFault_reg <= 1'b1;
        end else if (wrCtrl1 && faultArm_reg) begin
            modeFault_reg <= 1'b0;
        end
    end

    // interrupt requests
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            txIrq <= 1'b0;
            rxFaultIrq <= 1'b0;
        end else begin
            txIrq <= txEmpty_reg && ctrl1_reg[sbr_pkg::C1_TXIE];
            rxFaultIrq <= (rxFull_reg || modeFault_reg)
                && ctrl1_reg[sbr_pkg::C1_RXIE];
        end
    end

    a_fault_gate: assert property (@(posedge mclk) disable iff (rst)
        $rose(modeFault_reg) |-> $past(faultMode) && !$past(selectInN))
        else $error("mode fault set outside fault mode");
    a_fault_set: assert property (@(posedge mclk) disable iff (rst)
        faultMode && !selectInN |=> modeFault_reg)
        else $error("mode fault not set");
    a_fault_clear: assert property (@(posedge mclk) disable iff (rst)
        $fell(modeFault_reg) |-> $past(wrCtrl1) && $past(faultArm_reg))
        else $error("mode fault cleared without sequence");
    a_rx_clear: assert property (@(posedge mclk) disable iff (rst)
        $fell(rxFull_reg) && $past(enabled) |-> $past(rdData)
        && $past(rxArm_reg))
        else $error("receive full cleared without sequence");
    a_rx_set: assert property (@(posedge mclk) disable iff (rst)
        shiftDone && enabled |=> rxFull_reg)
        else $error("receive full not set at completion");
    a_rx_keep: assert property (@(posedge mclk) disable iff (rst)
        shiftDone && rxFull_reg |=> $stable(rxBuf_reg))
        else $error("overrun overwrote buffer");
    a_tx_discard: assert property (@(posedge mclk) disable iff (rst)
        wrData && !txArm_reg && !loadShift |=> $stable(txPending_reg))
        else $error("unarmed data write taken");
    a_idle_load: assert property (@(posedge mclk) disable iff (rst)
        wrData && txArm_reg && txEmpty_reg && enabled && master
        && !busy_reg |-> ##[1:2] txEmpty_reg && busy_reg)
        else $error("idle load too slow");
    a_tx_irq: assert property (@(posedge mclk) disable iff (rst)
        txEmpty_reg && ctrl1_reg[sbr_pkg::C1_TXIE] |=> txIrq)
        else $error("transmit irq missing");
    a_disable: assert property (@(posedge mclk) disable iff (rst)
        !enabled |=> txEmpty_reg && !rxFull_reg && !busy_reg)
        else $error("disable did not reset flags");
    a_stat_zero: assert property (@(posedge mclk) disable iff (rst)
        rdStat |=> hrdata[6] == 1'b0 && hrdata[3:0] == 4'h0)
        else $error("reserved status bits set");

    // transmit path checks
    a_txe_room: assert property (@(posedge mclk) disable iff (rst)
        txEmpty_reg != txPending_reg)
        else $error("transmit empty disagrees with buffer");
    a_tx_accept: assert property (@(posedge mclk) disable iff (rst)
        wrData && txArm_reg && txEmpty_reg && enabled |=> !txEmpty_reg)
        else $error("armed data write not taken");
    a_tx_refill: assert property (@(posedge mclk) disable iff (rst)
        shiftDone && txPending_reg && enabled && master
        |=> txEmpty_reg && busy_reg && !txPending_reg)
        else $error("queued byte not moved at completion");
    a_tx_keep: assert property (@(posedge mclk) disable iff (rst)
        shiftDone && !txPending_reg && !wrData && enabled
        |=> txEmpty_reg && !busy_reg)
        else $error("empty flag lost or shifter restarted");
    a_start_load: assert property (@(posedge mclk) disable iff (rst)
        enabled && master && txPending_reg && !busy_reg
        |=> busy_reg && txEmpty_reg)
        else $error("master write did not start transfer");

    // bus and interrupt checks
    a_bus_okay: assert property (@(posedge mclk) disable iff (rst)
        hreadyout && !hresp)
        else $error("bus response not ready and okay");
    a_rate_read: assert property (@(posedge mclk) disable iff (rst)
        addrPhase && !hwrite && haddr == sbr_pkg::OFF_RATE
        |=> hrdata == {24'h0, $past(rate_reg)})
        else $error("rate read returned wrong value");
    a_rx_irq: assert property (@(posedge mclk) disable iff (rst)
        (rxFull_reg || modeFault_reg) && ctrl1_reg[sbr_pkg::C1_RXIE]
        |=> rxFaultIrq)
        else $error("receive or fault irq missing");
endmodule : sbr_spi_core

// >>> verification/sbr_peer.sv
// sbr_peer: slave device on the link; shifts bytes out and captures in.
// assumes master clock idles low, samples on rise, changes on fall.
`timescale 1ns/1ps
module sbr_peer (
    // link
    input wire logic serialClock,
    input wire logic dataOut,
    output logic dataIn,
    // byte trace
    input wire logic [7:0] sendByte,
    output logic [7:0] gotByte,
    output int nBytes
);
    logic [7:0] sh;
    logic [2:0] bitN;
    logic [7:0] cur;
    // next outgoing byte steps by one per finished frame
    assign cur = sendByte + nBytes[7:0];
    initial begin
        sh = 8'h00;
        bitN = 3'h0;
        nBytes = 0;
        gotByte = 8'h00;
        #1 dataIn = sendByte[7];
    end
    // sample master data on rising clock, msb first
    always @(posedge serialClock) begin
        sh = {sh[6:0], dataOut};
        if (bitN == 3'h7) begin
            gotByte = sh;
            nBytes++;
        end
        bitN = bitN + 3'h1;
    end
    // change our bit on falling clock, next msb between frames
    always @(negedge serialClock) begin
        dataIn = cur[3'h7 - bitN];
    end
endmodule : sbr_peer

// >>> verification/sbr_spi_core_bench.sv
// sbr_spi_core_bench: drives the core over ahb-lite, peer on the link.
// assumes sbr_peer as far side and one 25 MHz clock.
`timescale 1ns/1ps
module sbr_spi_core_bench;
    logic mclk, rst, hsel, hwrite, hready, selectInN, obsStb;
    logic [7:0] haddr, sendByte, gotByte, b, pr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, obsVal, expQ[$];
    logic hreadyout, hresp, dataIn, dataOut, serialClock, txIrq, rxFaultIrq;
    string nameQ[$];
    int failures, nChecks, cyc, nBytes, k, hp, t0;
    logic [15:0] mf[4] = '{16'h10d0, 16'h00d0, 16'h10d2, 16'h10c0};
    sbr_spi_core DUT (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .selectInN(selectInN), .dataIn(dataIn),
        .dataOut(dataOut), .serialClock(serialClock), .txIrq(txIrq),
        .rxFaultIrq(rxFaultIrq));
    sbr_peer peer (.serialClock(serialClock), .dataOut(dataOut),
        .dataIn(dataIn), .sendByte(sendByte), .gotByte(gotByte),
        .nBytes(nBytes));
    assign hready = hreadyout;
    // clock and cycle ceiling
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            report_and_stop();
        end
    end
    // result watcher: oldest note against each posted result
    always @(posedge mclk) begin
        if (obsStb === 1'b1) begin
            chk(nameQ.pop_front(), expQ.pop_front(), obsVal);
        end
    end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        nChecks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic note(logic [31:0] e, string nm);
        expQ.push_back(e);
        nameQ.push_back(nm);
    endtask : note
    task automatic post(logic [31:0] v);
        obsVal <= v;
        obsStb <= 1'b1;
        @(posedge mclk);
        obsStb <= 1'b0;
        @(posedge mclk); // keeps back-to-back posts apart
    endtask : post
    // one single word transfer, entered just after a rising edge
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= sbr_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        r = hrdata;
    endtask : bus
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
        logic [31:0] r;
        note(e, nm);
        bus(1'b0, a, 32'h0, r);
        post(r);
    endtask : rd
    task automatic report_and_stop();
        $display("checks %0d failures %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // main sequence
    initial begin
        {rst, hsel, hwrite, obsStb, htrans, haddr, hwdata} = '1;
        {hsel, hwrite, obsStb, htrans, haddr, hwdata} = '0;
        {failures, nChecks, cyc} = '0;
        hsize = 3'h2;
        selectInN = 1'b1;
        void'($urandom(32'h3577));
        sendByte = 8'($urandom());
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // reset values, unarmed write, map holes
        rd(sbr_pkg::OFF_CTRL1, 32'h04, "ctrl1");
        rd(sbr_pkg::OFF_RATE, 32'h00, "rate");
        wr(sbr_pkg::OFF_CTRL1, 32'h50);
        wr(sbr_pkg::OFF_DATA, 32'h5a);
        repeat (40) @(posedge mclk);
        note(0, "peer count");
        post(nBytes);
        rd(sbr_pkg::OFF_STAT, 32'h20, "status");
        wr(sbr_pkg::OFF_STAT, 32'hff);
        rd(sbr_pkg::OFF_STAT, 32'h20, "status");
        wr(8'h40, 32'hff);
        rd(8'h40, 32'h0, "unmapped");
        note(32'h0, "hresp");
        post(32'(hresp));
        for (int i = 0; i < 4; i++) begin
            hwdata <= hwdata;
            k = $urandom();
            wr(sbr_pkg::OFF_RATE, k);
            rd(sbr_pkg::OFF_RATE, k & 32'h77, "rate");
        end
        $display("test reset_map done");
        // bit rate settings, one byte each
        for (int i = 0; i < 4; i++) begin
            pr = (i == 3) ? {1'b0, 3'($urandom()), 4'h2} : 8'(i * 8'h38);
            hp = (pr[6:4] + 1) << pr[2:0];
            b = 8'($urandom());
            k = nBytes;
            wr(sbr_pkg::OFF_RATE, pr);
            rd(sbr_pkg::OFF_STAT, 32'h20, "status");
            wr(sbr_pkg::OFF_DATA, b);
            @(posedge serialClock);
            t0 = cyc;
            @(posedge serialClock);
            note(2 * hp, "bit period");
            post(cyc - t0);
            repeat (16 * hp + 8) @(posedge mclk);
            note(b, "peer byte");
            post(gotByte);
            rd(sbr_pkg::OFF_STAT, 32'ha0, "status");
            rd(sbr_pkg::OFF_DATA, 8'(sendByte + k), "data");
            rd(sbr_pkg::OFF_STAT, 32'h20, "status");
        end
        $display("test bit_rate done");
        // two queued bytes, second reception dropped
        wr(sbr_pkg::OFF_RATE, 32'h11);
        k = nBytes;
        rd(sbr_pkg::OFF_STAT, 32'h20, "status");
        wr(sbr_pkg::OFF_DATA, 32'h3c);
        repeat (2) @(posedge mclk);
        rd(sbr_pkg::OFF_STAT, 32'h20, "status");
        wr(sbr_pkg::OFF_DATA, 32'hc5);
        rd(sbr_pkg::OFF_STAT, 32'h00, "status");
        repeat (150) @(posedge mclk);
        rd(sbr_pkg::OFF_STAT, 32'ha0, "status");
        note(32'hc5, "peer byte");
        post(gotByte);
        rd(sbr_pkg::OFF_DATA, 8'(sendByte + k), "data");
        $display("test queue done");
        // transmit interrupt, then mode fault settings
        wr(sbr_pkg::OFF_CTRL1, 32'h70);
        repeat (2) @(posedge mclk);
        note(1, "txIrq");
        post(txIrq);
        wr(sbr_pkg::OFF_CTRL1, 32'h50);
        repeat (2) @(posedge mclk);
        note(0, "txIrq");
        post(txIrq);
        for (int i = 0; i < 4; i++) begin
            wr(sbr_pkg::OFF_CTRL2, mf[i][15:8]);
            wr(sbr_pkg::OFF_CTRL1, mf[i][7:0]);
            selectInN <= 1'b0;
            repeat (3) @(posedge mclk);
            note(i == 0, "rxFaultIrq");
            post(rxFaultIrq);
            rd(sbr_pkg::OFF_STAT, i == 0 ? 32'h30 : 32'h20, "st");
            selectInN <= 1'b1;
            wr(sbr_pkg::OFF_CTRL1, mf[i][7:0]);
            rd(sbr_pkg::OFF_STAT, 32'h20, "status");
        end
        $display("test fault done");
        // disable in mid transfer
        wr(sbr_pkg::OFF_CTRL1, 32'h50);
        wr(sbr_pkg::OFF_RATE, 32'h03);
        rd(sbr_pkg::OFF_STAT, 32'h20, "status");
        wr(sbr_pkg::OFF_DATA, 32'h81);
        repeat (30) @(posedge mclk);
        wr(sbr_pkg::OFF_CTRL1, 32'h00);
        repeat (200) @(posedge mclk);
        note(0, "serialClock");
        post(serialClock);
        rd(sbr_pkg::OFF_STAT, 32'h20, "status");
        $display("test disable done");
        report_and_stop();
    end
endmodule : sbr_spi_core_bench
